// ### logic/hccmd_pkg.sv
// Purpose: Constants for the function command control register
// Assumes: Standard type 0 header bit layout
// Notes:   Shared by the register block and its gate helper
package hccmd_pkg;
  localparam logic [7:0]  HCCMD_OFFSET      = 8'h04;
  localparam int          HCCMD_W           = 16;
  localparam int          BIT_IO_EN         = 0;
  localparam int          BIT_MEM_EN        = 1;
  localparam int          BIT_MASTER_EN     = 2;
  localparam int          BIT_SPECIAL_CYC   = 3;
  localparam int          BIT_MWI_EN        = 4;
  localparam int          BIT_PALETTE_SNOOP = 5;
  localparam int          BIT_PARITY_RESP   = 6;
  localparam int          BIT_WAIT_CYC      = 7;
  localparam int          BIT_SYSERR_EN     = 8;
  localparam int          BIT_FAST_B2B      = 9;
  localparam int          BIT_INTX_DISABLE  = 10;
  // Writable bits: 0,1,2,6,8,10; everything else reads zero
  localparam logic [15:0] HCCMD_RW_MASK     = 16'h0547;
  localparam logic [15:0] HCCMD_RESET       = 16'h0000;
endpackage : hccmd_pkg

// ### logic/hccmd_gate.sv
// Purpose: Gates function traffic by the command register enables
// Assumes: All requests arrive on the device clock
// Notes:   Purely combinational, so an enable change acts at once
`timescale 1ns/10ps
module hccmd_gate
  import hccmd_pkg::*;
(
  input  wire logic [HCCMD_W-1:0] cmd_i,
  input  wire logic               io_req_i,
  input  wire logic               mem_req_i,
  input  wire logic               master_req_i,
  input  wire logic               intx_req_i,
  input  wire logic               err_i,
  input  wire logic               parity_err_i,
  output logic                    io_accept_o,
  output logic                    mem_accept_o,
  output logic                    master_go_o,
  output logic                    intx_msg_o,
  output logic                    err_report_o,
  output logic                    parity_act_o
);
  // Each request passes only while its enable bit is set; INTx passes only while its disable bit is clear
  assign io_accept_o  = io_req_i & cmd_i[BIT_IO_EN];               // RQ1
  assign mem_accept_o = mem_req_i & cmd_i[BIT_MEM_EN];             // RQ2
  assign master_go_o  = master_req_i & cmd_i[BIT_MASTER_EN];       // RQ3
  assign intx_msg_o   = intx_req_i & ~cmd_i[BIT_INTX_DISABLE];     // RQ9
  assign err_report_o = err_i & cmd_i[BIT_SYSERR_EN];              // RQ6
  assign parity_act_o = parity_err_i & cmd_i[BIT_PARITY_RESP];     // RQ5
endmodule : hccmd_gate

// ### logic/hccmd_reg.sv
// Purpose: Function command control register with traffic gating
// Assumes: Config write/read strobes come from the device clock domain
// Notes:   Byte enables select lanes; read data is registered
`timescale 1ns/10ps
// How it works
// RQ1 - Bit 0 enables I/O space responses; reset clear ignores them.
// RQ2 - Bit 1 enables memory space responses; reset clear declines them.
// RQ3 - Bit 2 allows the function to master upstream requests; reset zero.
// RQ4 - Legacy control bits are read-only zero; writes ignored.
// RQ5 - Bit 6 enables normal parity action; else only status flag set.
// RQ6 - Bit 8 enables reporting fatal and non-fatal errors upstream.
// RQ7 - A control bit governs whether INTx messages may be emitted.
// RQ8 - Root complex must set memory and master enables before expecting traffic.
// RQ9 - Bit 10 set suppresses INTx messages; reset value zero.
module hccmd_reg
  import hccmd_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               cfg_wr_i,
  input  wire logic               cfg_rd_i,
  input  wire logic [7:0]         cfg_addr_i,
  input  wire logic [1:0]         cfg_be_i,
  input  wire logic [HCCMD_W-1:0] cfg_wdata_i,
  output logic      [HCCMD_W-1:0] cfg_rdata_o,
  input  wire logic               io_req_i,
  input  wire logic               mem_req_i,
  input  wire logic               master_req_i,
  input  wire logic               intx_req_i,
  input  wire logic               err_i,
  input  wire logic               parity_err_i,
  output logic                    io_accept_o,
  output logic                    mem_accept_o,
  output logic                    master_go_o,
  output logic                    intx_msg_o,
  output logic                    err_report_o,
  output logic                    parity_act_o,
  output logic                    parity_status_o,
  output logic [HCCMD_W-1:0]      cmd_o
);
  logic [HCCMD_W-1:0] cmd_q;
  logic [HCCMD_W-1:0] cmd_d;
  logic [HCCMD_W-1:0] lane_mask;
  logic               hit;

  ////////////////////////////////////////////////////////////////////////////
  // Write path
  assign hit       = (cfg_addr_i == HCCMD_OFFSET);
  assign lane_mask = {{8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};
  // Only writable bits can change, so hardwired controls stay zero
  assign cmd_d = (cmd_q & ~(lane_mask & HCCMD_RW_MASK))
               | (cfg_wdata_i & lane_mask & HCCMD_RW_MASK);           // RQ4

  // All enables, including the INTx control, clear on reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_q <= HCCMD_RESET;                                           // RQ7
    end else if (cfg_wr_i && hit) begin
      cmd_q <= cmd_d;
    end
  end

  // Registered read; unmapped offsets read zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_rdata_o <= '0;
    end else if (cfg_rd_i) begin
      cfg_rdata_o <= hit ? cmd_q : '0;
    end
  end

  // Detected parity flag sets regardless of response enable; sticky
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      parity_status_o <= 1'b0;
    end else if (parity_err_i) begin
      parity_status_o <= 1'b1;                                        // RQ5
    end
  end

  assign cmd_o = cmd_q;

  ////////////////////////////////////////////////////////////////////////////
  // Traffic gating; until software sets the enables nothing passes but INTx, which flows until bit 10 is set
  hccmd_gate u_gate (                                                 // RQ8
    .cmd_i        (cmd_q),
    .io_req_i     (io_req_i),
    .mem_req_i    (mem_req_i),
    .master_req_i (master_req_i),
    .intx_req_i   (intx_req_i),
    .err_i        (err_i),
    .parity_err_i (parity_err_i),
    .io_accept_o  (io_accept_o),
    .mem_accept_o (mem_accept_o),
    .master_go_o  (master_go_o),
    .intx_msg_o   (intx_msg_o),
    .err_report_o (err_report_o),
    .parity_act_o (parity_act_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_io_gate;
    @(posedge clk_i) disable iff (rst_i)
      io_accept_o |-> (io_req_i && cmd_q[BIT_IO_EN]);
  endproperty
  a_io_gate: assert property (p_io_gate) else $error("io accepted while off"); // RQ1

  property p_mem_gate;
    @(posedge clk_i) disable iff (rst_i)
      (mem_req_i && !cmd_q[BIT_MEM_EN]) |-> !mem_accept_o;
  endproperty
  a_mem_gate: assert property (p_mem_gate) else $error("mem accepted while off"); // RQ2

  property p_master_gate;
    @(posedge clk_i) disable iff (rst_i)
      (master_req_i && cmd_q[BIT_MASTER_EN]) == master_go_o;
  endproperty
  a_master_gate: assert property (p_master_gate) else $error("master gate wrong"); // RQ3

  property p_ro_zero;
    @(posedge clk_i) disable iff (rst_i)
      (cmd_q & ~HCCMD_RW_MASK) == '0;
  endproperty
  a_ro_zero: assert property (p_ro_zero) else $error("hardwired bit set"); // RQ4

  sequence s_wr_full;
    cfg_wr_i && hit && (cfg_be_i == 2'b11);
  endsequence

  property p_write_lands;
    @(posedge clk_i) disable iff (rst_i)
      s_wr_full |=> (cmd_q == ($past(cfg_wdata_i) & HCCMD_RW_MASK));
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("write not stored"); // RQ7

  property p_parity;
    @(posedge clk_i) disable iff (rst_i)
      parity_err_i |=> parity_status_o;
  endproperty
  a_parity: assert property (p_parity) else $error("parity flag not set"); // RQ5

  property p_err_rep;
    @(posedge clk_i) disable iff (rst_i)
      err_report_o |-> (err_i && cmd_q[BIT_SYSERR_EN]);
  endproperty
  a_err_rep: assert property (p_err_rep) else $error("error reported while off"); // RQ6

  property p_intx;
    @(posedge clk_i) disable iff (rst_i)
      cmd_q[BIT_INTX_DISABLE] |-> !intx_msg_o;
  endproperty
  a_intx: assert property (p_intx) else $error("intx while disabled"); // RQ9

  property p_readback;
    @(posedge clk_i) disable iff (rst_i)
      (cfg_rd_i && hit && !cfg_wr_i) |=> (cfg_rdata_o == $past(cmd_q));
  endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch"); // RQ4

  // The closed-gate checks above would also hold for a gate stuck shut,
  // so each gate is checked in the open direction as well
  property p_io_open;
    @(posedge clk_i) disable iff (rst_i)
      (io_req_i && cmd_q[BIT_IO_EN]) |-> io_accept_o;
  endproperty
  a_io_open: assert property (p_io_open) else $error("io refused while on"); // RQ1

  property p_mem_open;
    @(posedge clk_i) disable iff (rst_i)
      (mem_req_i && cmd_q[BIT_MEM_EN]) |-> mem_accept_o;
  endproperty
  a_mem_open: assert property (p_mem_open) else $error("mem refused while on"); // RQ2

  property p_err_open;
    @(posedge clk_i) disable iff (rst_i)
      (err_i && cmd_q[BIT_SYSERR_EN]) |-> err_report_o;
  endproperty
  a_err_open: assert property (p_err_open) else $error("error not reported while on"); // RQ6

  property p_intx_open;
    @(posedge clk_i) disable iff (rst_i)
      (intx_req_i && !cmd_q[BIT_INTX_DISABLE]) |-> intx_msg_o;
  endproperty
  a_intx_open: assert property (p_intx_open) else $error("intx blocked while allowed"); // RQ7

  // Normal parity action only while the response enable is set
  property p_parity_act;
    @(posedge clk_i) disable iff (rst_i)
      parity_act_o == (parity_err_i && cmd_q[BIT_PARITY_RESP]);
  endproperty
  a_parity_act: assert property (p_parity_act) else $error("parity action wrong"); // RQ5

  // Writes that miss the register or select no lane leave it untouched
  sequence s_wr_miss;
    cfg_wr_i && (!hit || (cfg_be_i == 2'b00));
  endsequence

  property p_wr_miss;
    @(posedge clk_i) disable iff (rst_i)
      s_wr_miss |=> $stable(cmd_q);
  endproperty
  a_wr_miss: assert property (p_wr_miss) else $error("stray write changed register"); // RQ4

  // Unmapped offsets must read as zero
  property p_read_miss;
    @(posedge clk_i) disable iff (rst_i)
      (cfg_rd_i && !hit) |=> (cfg_rdata_o == '0);
  endproperty
  a_read_miss: assert property (p_read_miss) else $error("unmapped read not zero"); // RQ4

  // Setting the interrupt disable shuts messages from the next cycle on
  sequence s_intx_off;
    cfg_wr_i && hit && lane_mask[BIT_INTX_DISABLE] && cfg_wdata_i[BIT_INTX_DISABLE];
  endsequence

  property p_intx_off;
    @(posedge clk_i) disable iff (rst_i)
      s_intx_off |=> !intx_msg_o;
  endproperty
  a_intx_off: assert property (p_intx_off) else $error("intx after disable write"); // RQ9

  // Clearing the master enable stops own requests from the next cycle on
  sequence s_master_off;
    cfg_wr_i && hit && lane_mask[BIT_MASTER_EN] && !cfg_wdata_i[BIT_MASTER_EN];
  endsequence

  property p_master_off;
    @(posedge clk_i) disable iff (rst_i)
      s_master_off |=> !master_go_o;
  endproperty
  a_master_off: assert property (p_master_off) else $error("master after clear"); // RQ3

  // Detected parity flag has no clear besides reset
  property p_parity_sticky;
    @(posedge clk_i) disable iff (rst_i)
      parity_status_o |=> parity_status_o;
  endproperty
  a_parity_sticky: assert property (p_parity_sticky) else $error("parity flag lost"); // RQ5
endmodule : hccmd_reg

// ### verif/hccmd_rc_model.sv
// Purpose: Root complex stand-in issuing config accesses
// Assumes: Tasks are entered just after a rising edge
// Notes:   Strobes last one cycle; released data is scrambled
`timescale 1ns/10ps
module hccmd_rc_model
  import hccmd_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic [HCCMD_W-1:0] rdata_i,
  output logic                    wr_o,
  output logic                    rd_o,
  output logic      [7:0]         addr_o,
  output logic      [1:0]         be_o,
  output logic      [HCCMD_W-1:0] wdata_o
);
  // Idle bus at time zero
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    be_o = 2'h0;
    wdata_o = 16'h0000;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Write held up to its sampling edge only
  task automatic cfg_write(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
    wr_o <= 1'b1;
    addr_o <= a;
    be_o <= b;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d; // Stale data must never look valid
  endtask : cfg_write
  // Read data is taken at the edge after the one that launches it
  task automatic cfg_read(input logic [7:0] a, output logic [15:0] d);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(posedge clk_i);
    d = rdata_i;
  endtask : cfg_read
endmodule : hccmd_rc_model

// ### verif/host_ctrl_command_register_tb.sv
// Purpose: Random and corner checks of the command register
// Assumes: Partner model drives all config traffic
// Notes:   Expectations come from the bench's own functions
`timescale 1ns/10ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin bad_count++; \
  $display("unexpected %s exp %h seen %h", n, e, s); end end
module host_ctrl_command_register_tb
  import hccmd_pkg::*;
;
  logic        clk_i, rst_i, wr, rd, pst, pst_o;
  logic [7:0]  addr, a;
  logic [1:0]  be, b;
  logic [15:0] wdata, rdata, cmd, exp_q, d, got;
  logic [5:0]  req;
  wire logic [5:0] acc;
  int          bad_count, tests_run, cyc, seed = 32'hef5973ae;
  hccmd_reg u_hccmd_reg (.clk_i(clk_i), .rst_i(rst_i), .cfg_wr_i(wr), .cfg_rd_i(rd),
    .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wdata), .cfg_rdata_o(rdata),
    .io_req_i(req[0]), .mem_req_i(req[1]), .master_req_i(req[2]), .intx_req_i(req[3]),
    .err_i(req[4]), .parity_err_i(req[5]), .io_accept_o(acc[0]), .mem_accept_o(acc[1]),
    .master_go_o(acc[2]), .intx_msg_o(acc[3]), .err_report_o(acc[4]),
    .parity_act_o(acc[5]), .parity_status_o(pst_o), .cmd_o(cmd));
  hccmd_rc_model rc (.clk_i(clk_i), .rdata_i(rdata), .wr_o(wr), .rd_o(rd), .addr_o(addr),
    .be_o(be), .wdata_o(wdata));
  //////////////////////////////////////////////////////////////////////////////
  // Only writable bits of enabled lanes change
  function automatic logic [15:0] exp_wr(input logic [15:0] o, input logic [1:0] bl,
                                         input logic [15:0] v);
    logic [15:0] m;
    m = {{8{bl[1]}}, {8{bl[0]}}} & HCCMD_RW_MASK;
    exp_wr = (o & ~m) | (v & m);
  endfunction : exp_wr
  // Each gate opens on its enable; interrupts close on the disable bit
  function automatic logic [5:0] exp_gate(input logic [15:0] c, input logic [5:0] r);
    exp_gate = r & {c[BIT_PARITY_RESP], c[BIT_SYSERR_EN], ~c[BIT_INTX_DISABLE],
                    c[BIT_MASTER_EN], c[BIT_MEM_EN], c[BIT_IO_EN]};
  endfunction : exp_gate
  // Counts, then the single verdict
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Hang guard, well above the expected run length
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      give_verdict();
    end
  end
  // Reset, corner writes, then random traffic
  initial begin
    rst_i = 1'b1;
    req = 6'h00;
    exp_q = HCCMD_RESET;
    pst = 1'b0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 `CHK("reset", HCCMD_RESET, cmd)
    for (int i = 0; i < 300; i++) begin
      // Mid-run reset: the register and the sticky parity flag must clear
      if (i == 150) begin
        @(posedge clk_i);
        rst_i <= 1'b1;
        req   <= 6'h00;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        exp_q = HCCMD_RESET;
        pst   = 1'b0;
        #1 `CHK("cmd after reset", HCCMD_RESET, cmd)
        `CHK("parity flag after reset", 1'b0, pst_o)
      end
      @(posedge clk_i);
      a = (i < 2 || ($random(seed) & 3)) ? HCCMD_OFFSET : 8'h08;
      b = (i < 2) ? 2'h3 : 2'($random(seed));
      d = (i == 0) ? 16'hffff : 16'($random(seed)); // Enables set before traffic
      req <= 6'($random(seed));
      rc.cfg_write(a, b, d);
      if (a == HCCMD_OFFSET) exp_q = exp_wr(exp_q, b, d);
      pst = pst | req[5];
      #1 `CHK("cmd", exp_q, cmd)
      `CHK("gates", exp_gate(exp_q, req), acc)
      `CHK("parity flag", pst, pst_o)
      @(posedge clk_i);
      rc.cfg_read(a, got);
      `CHK("readback", (a == HCCMD_OFFSET) ? exp_q : 16'h0000, got)
    end
    give_verdict();
  end
endmodule : host_ctrl_command_register_tb
